// ==== core/rml_pkg.sv ====
package rml_pkg;
   // register map, byte offsets of the configuration space
   localparam logic [6:0] RML_OFS_INPUT_TWO_LIMIT = 7'h49;
   localparam logic [6:0] RML_OFS_INPUT_THREE_LIMIT = 7'h4a;
   localparam logic [6:0] RML_OFS_INPUT_ZERO_TOL = 7'h4b;
   localparam logic [7:0] RML_RST_LIMIT = 8'h0a;
   localparam logic [7:0] RML_RST_TOL = 8'h55;
   // tolerance register fields
   localparam int RML_CFM_LSB = 0;
   localparam int RML_SCM_LSB = 4;
   localparam int RML_TOL_W = 3;
   // period measurement in units of the sampling step
   localparam int RML_CORE_PERIOD_PS = 20000;
   localparam int RML_SAMPLE_PERIOD_PS = 1250;
   localparam int RML_UNITS_PER_CLK = RML_CORE_PERIOD_PS / RML_SAMPLE_PERIOD_PS;
   localparam int RML_PER_W = 24;
   localparam logic [23:0] RML_PER_MAX = 24'hff_ffff;
   localparam int RML_WIN_LOG2 = 4;
   localparam logic [15:0] RML_PERMIL = 16'h03e8;

   typedef logic [RML_PER_W-1:0] rml_period_t;

   // tolerance code to parts per thousand
   function automatic logic [9:0] rml_tol_permil(input logic [2:0] code);
      case (code)
         3'h0: rml_tol_permil = 10'h001;
         3'h1: rml_tol_permil = 10'h005;
         3'h2: rml_tol_permil = 10'h00a;
         3'h3: rml_tol_permil = 10'h014;
         3'h4: rml_tol_permil = 10'h032;
         3'h5: rml_tol_permil = 10'h064;
         3'h6: rml_tol_permil = 10'h0c8;
         default: rml_tol_permil = 10'h1f4;
      endcase
   endfunction
endpackage

// ==== core/rml_period_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface rml_period_if;
   import rml_pkg::*;
   logic valid;
   rml_period_t period;
   modport meas (output valid, output period);
   modport core (input valid, input period);
endinterface
`default_nettype wire

// ==== core/rml_period_meas.sv ====
`timescale 1ns/100ps
`default_nettype none
module rml_period_meas
   import rml_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // reference pin
   input wire logic ref_in,
   // measured periods
   rml_period_if.meas pm
);
   logic s1, s2, s3, level;
   rml_period_t count;
   logic seen_edge;
   // a change counts only once the last two stages agree
   wire agree = (s2 == s3);
   wire rise = agree & s3 & ~level;
   wire stall = (count >= RML_PER_MAX - RML_PER_W'(RML_UNITS_PER_CLK));
   wire rml_period_t next_count = (rise | stall) ? RML_PER_W'(RML_UNITS_PER_CLK)
                                                 : count + RML_PER_W'(RML_UNITS_PER_CLK);

   always_ff @(posedge core_clk_in) begin
      s1 <= ref_in;
      s2 <= s1;
      s3 <= s2;
   end

   // counts in sampling steps; a dead input reports a saturated period
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         // follow the pin during reset so release shows no false edge
         level <= s3;
         count <= '0;
         seen_edge <= 1'b0;
         pm.valid <= 1'b0;
         pm.period <= '0;
      end else begin
         if (agree) level <= s3;
         count <= next_count;
         if (rise) seen_edge <= 1'b1;
         pm.valid <= (rise & seen_edge) | stall;
         if ((rise & seen_edge) | stall) pm.period <= count;
      end
   end
endmodule // rml_period_meas
`default_nettype wire

// ==== core/rml_ref_monitor_limit_config.sv ====
// Functional notes
// - phase hold limits are 8-bit codes, round(32*log(limit*1e5)), stored as written
// - codes 0x00,0x20,0x40,0x9F mean 10us,100us,1ms,930ms; passed through unchanged
// - input zero coarse tolerance in bits 2:0, 0.1% up to 50%
// - coarse frequency failure raised when input zero leaves its tolerance
// - input zero single period tolerance in bits 6:4, same coding
// - single period failure raised when one period breaks its tolerance
// - periods measured in 1.25 ns steps, the 800 MHz sampling grid
`timescale 1ns/100ps
`default_nettype none
module rml_ref_monitor_limit_config
   import rml_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // register port
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // input zero pin and its nominal period in 1.25 ns steps
   input wire logic input_zero_in,
   input wire logic [23:0] input_zero_nominal_in,
   // limits for the phase hold logic
   output logic [7:0] input2_phase_hold_limit_out,
   output logic [7:0] input3_phase_hold_limit_out,
   // failure indicators
   output logic input_zero_coarse_fail_out,
   output logic input_zero_single_fail_out
);
   logic [7:0] input2_phase_hold_limit;
   logic [7:0] input3_phase_hold_limit;
   logic [2:0] input0_coarse_freq_tolerance;
   logic [2:0] input0_single_period_tolerance;
   logic [27:0] win_sum;
   logic [3:0] win_cnt;

   rml_period_if pm ();
   rml_period_meas u_meas (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ref_in(input_zero_in),
      .pm(pm.meas)
   );

   // register decode
   wire sel_input_two = (reg_addr_in == RML_OFS_INPUT_TWO_LIMIT);
   wire sel_input_three = (reg_addr_in == RML_OFS_INPUT_THREE_LIMIT);
   wire sel_tol = (reg_addr_in == RML_OFS_INPUT_ZERO_TOL);
   wire wr_input_two = reg_wr_in & sel_input_two;
   wire wr_input_three = reg_wr_in & sel_input_three;
   wire wr_tol = reg_wr_in & sel_tol;
   // reserved bits 3 and 7 read zero
   wire [7:0] tol_word = {1'b0, input0_single_period_tolerance,
                          1'b0, input0_coarse_freq_tolerance};
   wire [7:0] next_rdata = sel_input_two ? input2_phase_hold_limit :
                           sel_input_three ? input3_phase_hold_limit :
                           sel_tol ? tol_word : 8'h00;

   // single period check: |p - nom| * 1000 > nom * tol
   wire [23:0] nom = input_zero_nominal_in;
   wire [23:0] sp_diff = (pm.period > nom) ? pm.period - nom : nom - pm.period;
   wire [39:0] sp_lhs = 40'(sp_diff) * 40'(RML_PERMIL);
   wire [39:0] sp_rhs = 40'(nom) * 40'(rml_tol_permil(input0_single_period_tolerance));
   wire sp_bad = sp_lhs > sp_rhs;
   // coarse check averages a window of sixteen periods
   wire [27:0] next_sum = win_sum + 28'(pm.period);
   wire [27:0] win_nom = {nom, 4'h0};
   wire win_end = pm.valid & (win_cnt == 4'hf);
   wire [27:0] cf_diff = (next_sum > win_nom) ? next_sum - win_nom : win_nom - next_sum;
   wire [43:0] cf_lhs = 44'(cf_diff) * 44'(RML_PERMIL);
   wire [43:0] cf_rhs = 44'(win_nom) * 44'(rml_tol_permil(input0_coarse_freq_tolerance));
   wire cf_bad = cf_lhs > cf_rhs;

   // limits are stored exactly as written; the log scale lives downstream
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         input2_phase_hold_limit <= RML_RST_LIMIT;
      end else if (wr_input_two) begin
         input2_phase_hold_limit <= reg_wdata_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         input3_phase_hold_limit <= RML_RST_LIMIT;
      end else if (wr_input_three) begin
         input3_phase_hold_limit <= reg_wdata_in;
      end
   end

   // reserved bits 3 and 7 are dropped on write
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         input0_coarse_freq_tolerance <= RML_RST_TOL[RML_CFM_LSB +: RML_TOL_W];
         input0_single_period_tolerance <= RML_RST_TOL[RML_SCM_LSB +: RML_TOL_W];
      end else if (wr_tol) begin
         input0_coarse_freq_tolerance <= reg_wdata_in[RML_CFM_LSB +: RML_TOL_W];
         input0_single_period_tolerance <= reg_wdata_in[RML_SCM_LSB +: RML_TOL_W];
      end
   end

   // read data is registered, one cycle behind the address
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= next_rdata;
      end
   end

   // codes go out raw; the hold logic decodes the log scale
   assign input2_phase_hold_limit_out = input2_phase_hold_limit;
   assign input3_phase_hold_limit_out = input3_phase_hold_limit;

   // window of sixteen periods for the coarse check
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         win_sum <= '0;
         win_cnt <= '0;
      end else if (pm.valid) begin
         win_cnt <= win_cnt + 4'h1;
         win_sum <= win_end ? 28'h000_0000 : next_sum;
      end
   end

   // indicators follow each verdict, so they drop on a good verdict
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         input_zero_single_fail_out <= 1'b0;
      end else if (pm.valid) begin
         input_zero_single_fail_out <= sp_bad;
      end
   end

   // coarse verdict holds for a whole window; no software clear
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         input_zero_coarse_fail_out <= 1'b0;
      end else if (win_end) begin
         input_zero_coarse_fail_out <= cf_bad;
      end
   end

   chk_input_two_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_input_two |=> input2_phase_hold_limit_out == $past(reg_wdata_in))
      else $error("input_two limit not stored");
   chk_limit_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !wr_input_three |=> $stable(input3_phase_hold_limit_out))
      else $error("input_three limit changed without write");
   chk_coarse_field: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_tol ##1 !wr_tol |=> reg_addr_in != RML_OFS_INPUT_ZERO_TOL ||
         reg_rdata_out[2:0] == $past(reg_wdata_in[2:0], 2))
      else $error("coarse field readback wrong");
   chk_coarse_raise: assert property (@(posedge core_clk_in) disable iff (rst_in)
      win_end && cf_bad |=> input_zero_coarse_fail_out)
      else $error("coarse failure not raised");
   chk_single_field: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_tol |=> input0_single_period_tolerance == $past(reg_wdata_in[6:4]))
      else $error("single period field not stored");
   chk_single_raise: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pm.valid && sp_bad |=> input_zero_single_fail_out)
      else $error("single period failure not raised");
   chk_period_grid: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pm.valid |-> pm.period[3:0] == 4'h0 && pm.period != 24'h00_0000)
      else $error("period off the sampling grid");
   chk_fail_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pm.valid && !sp_bad ##1 !pm.valid [*2] |-> !input_zero_single_fail_out)
      else $error("single failure did not clear");
   // register side
   chk_input_three_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_input_three |=> input3_phase_hold_limit_out == $past(reg_wdata_in))
      else $error("input_three limit not stored");
   chk_input_two_hold: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !wr_input_two |=> $stable(input2_phase_hold_limit_out))
      else $error("input_two limit changed without write");
   chk_unmapped_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !$past(sel_input_two) && !$past(sel_input_three) && !$past(sel_tol) |-> reg_rdata_out == 8'h00)
      else $error("unmapped offset read nonzero");
   chk_reserved_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
      $past(sel_tol) |-> !reg_rdata_out[3] && !reg_rdata_out[7])
      else $error("reserved tolerance bits read nonzero");
   chk_coarse_readback: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !$past(rst_in) && $past(sel_tol) |->
         reg_rdata_out[2:0] == $past(input0_coarse_freq_tolerance))
      else $error("coarse code readback wrong");
   chk_single_readback: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !$past(rst_in) && $past(sel_tol) |->
         reg_rdata_out[6:4] == $past(input0_single_period_tolerance))
      else $error("single period code readback wrong");
   chk_coarse_store: assert property (@(posedge core_clk_in) disable iff (rst_in)
      wr_tol |=> input0_coarse_freq_tolerance == $past(reg_wdata_in[2:0]))
      else $error("coarse field not stored");
   // monitor side
   chk_coarse_steady: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !win_end |=> $stable(input_zero_coarse_fail_out))
      else $error("coarse failure moved inside a window");
   chk_single_steady: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !pm.valid |=> $stable(input_zero_single_fail_out))
      else $error("single failure moved without a verdict");
   chk_coarse_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
      win_end && !cf_bad |=> !input_zero_coarse_fail_out)
      else $error("coarse failure did not clear");
   chk_single_clear: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pm.valid && !sp_bad |=> !input_zero_single_fail_out)
      else $error("single failure not dropped on good period");
   chk_window_wrap: assert property (@(posedge core_clk_in) disable iff (rst_in)
      win_end |=> win_cnt == 4'h0)
      else $error("coarse window did not restart");

   cov_single_fail: cover property (@(posedge core_clk_in) disable iff (rst_in)
      $rose(input_zero_single_fail_out));
   cov_coarse_fail: cover property (@(posedge core_clk_in) disable iff (rst_in)
      $rose(input_zero_coarse_fail_out));
   cov_coarse_clear: cover property (@(posedge core_clk_in) disable iff (rst_in)
      $fell(input_zero_coarse_fail_out));
   cov_single_clear: cover property (@(posedge core_clk_in) disable iff (rst_in)
      $fell(input_zero_single_fail_out));
   cov_tol_write: cover property (@(posedge core_clk_in) disable iff (rst_in)
      wr_tol ##1 !wr_tol);
endmodule // rml_ref_monitor_limit_config
`default_nettype wire

// ==== bench/rml_ref_src.sv ====
`timescale 1ns/100ps
`default_nettype none
module rml_ref_src (
   // clock
   input wire logic core_clk_in,
   // period of the reference in core cycles
   input wire logic [15:0] period_in,
   // reference pin
   output logic ref_out
);
   logic [15:0] cnt = 16'h0000;
   initial ref_out = 1'b0;
   // edges land on the core clock, so the input sync sees them deterministically
   always @(posedge core_clk_in) begin
      cnt <= (cnt + 16'h0001 >= period_in) ? 16'h0000 : cnt + 16'h0001;
      ref_out <= (cnt < (period_in >> 1));
   end
endmodule // rml_ref_src
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rml_pkg::*;
   typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} rml_row_s;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [6:0] reg_addr_in = 7'h00;
   logic reg_wr_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic [23:0] input_zero_nominal_in = 24'h00_0140;
   logic [15:0] per = 16'h0014;
   logic [7:0] rdata, lim2, lim3, e2, e3;
   logic ref_pin, cfail, sfail, ef;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [9:0] pm [8] = '{10'h001, 10'h005, 10'h00a, 10'h014, 10'h032, 10'h064, 10'h0c8, 10'h1f4};
   rml_row_s rows [8] = '{'{7'h49, 8'h00, 8'h00}, '{7'h4a, 8'h20, 8'h20}, '{7'h4b, 8'hff, 8'h77},
      '{7'h48, 8'h5a, 8'h00}, '{7'h49, 8'h9f, 8'h9f}, '{7'h4a, 8'h40, 8'h40},
      '{7'h4b, 8'h88, 8'h00}, '{7'h7f, 8'hff, 8'h00}};
   always #10 core_clk_in = ~core_clk_in;
   rml_ref_src SRC (.core_clk_in(core_clk_in), .period_in(per), .ref_out(ref_pin));
   rml_ref_monitor_limit_config DUT (.core_clk_in(core_clk_in), .rst_in(rst_in),
      .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(rdata), .input_zero_in(ref_pin),
      .input_zero_nominal_in(input_zero_nominal_in), .input2_phase_hold_limit_out(lim2),
      .input3_phase_hold_limit_out(lim3), .input_zero_coarse_fail_out(cfail),
      .input_zero_single_fail_out(sfail));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      repeat (2) @(posedge core_clk_in);
      #1 chk(rdata, exp);
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ceiling well above the roughly 9k cycles the sequence needs
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic fails(input logic f);
      // one edge first so a period just changed by the caller is counted
      @(posedge core_clk_in);
      repeat (40 * per) @(posedge core_clk_in);
      #1 chk({7'h00, cfail}, {7'h00, f});
      chk({7'h00, sfail}, {7'h00, f});
   endtask
   initial begin
      e2 = 8'h0a;
      e3 = 8'h0a;
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      #1 chk(rdata, 8'h00);
      rd(7'h49, 8'h0a);
      rd(7'h4a, 8'h0a);
      rd(7'h4b, 8'h55);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         if (rows[i].a == 7'h49) e2 = rows[i].d;
         if (rows[i].a == 7'h4a) e3 = rows[i].d;
         rd(rows[i].a, rows[i].e);
         chk(lim2, e2);
         chk(lim3, e3);
      end
      wr(7'h4b, 8'h77);
      fails(1'b0);
      per <= 16'h0028;
      fails(1'b1);
      // reset in mid-run drops the failures and restores the tolerances
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      #1 chk({6'h00, cfail, sfail}, 8'h00);
      rd(7'h4b, 8'h55);
      // a 5 percent slow reference against every code, boundary at code 4
      per <= 16'h0015;
      for (int c = 0; c < 8; c++) begin
         wr(7'h4b, {1'b0, c[2:0], 1'b0, c[2:0]});
         ef = (32'd16000 > 32'd320 * pm[c]);
         fails(ef);
      end
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
